// *** logic/pio_rd_dev.sv ***
// pio_rd_dev.sv: device end of the host read port, serving csr and fifo reads
// assumes pins synchronous to i_clk; fifo words arrive on valid/ready streams
`timescale 1ns/1ps
`default_nettype none
`include "pio_rd_defines.svh"
module pio_rd_dev import pio_rd_pkg::*; #(
	parameter int BUS16 = 0
) (
	input wire logic i_clk,
	input wire logic i_rst,
	pio_rd_if.dev bus,
	input wire logic [31:0] i_rxd_data,
	input wire logic i_rxd_valid,
	output logic o_rxd_ready,
	input wire logic [31:0] i_rxs_data,
	input wire logic i_rxs_valid,
	output logic o_rxs_ready,
	input wire logic [31:0] i_txs_data,
	input wire logic i_txs_valid,
	output logic o_txs_ready,
	input wire logic [15:0] i_rx_fill,
	output logic o_active
);
	logic cyc_on;
	logic act_r;
	logic start;
	logic step;
	logic [7:1] addr_r;
	logic [31:0] free_cnt_r;
	logic [31:0] snap_r;
	logic [31:0] dout_r;
	logic [1:0] oe_r;
	logic [31:0] rd_val;
	rd_src_t src;
	logic pop;
	// two-entry skid buffer on rx data so a held-off pop loses no word
	logic [31:0] buf_d [2];
	logic [1:0] buf_cnt_r;
	logic buf_rd_r;
	logic buf_wr_r;
	logic push;
	logic take;

	assign cyc_on = !bus.host_select_n && !bus.host_read_strobe_n;
	assign start = cyc_on && !act_r;
	assign step = cyc_on && act_r && (bus.addr != addr_r);

	always_ff @(posedge i_clk) begin
		if (i_rst)
			act_r <= 1'b0;
		else
			act_r <= cyc_on;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			addr_r <= '0;
		else if (cyc_on)
			addr_r <= bus.addr;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			free_cnt_r <= '0;
		else
			free_cnt_r <= free_cnt_r + 32'h1;
	end

	// counter frozen at cycle start so a slow host sees one stable value
	always_ff @(posedge i_clk) begin
		if (i_rst)
			snap_r <= '0;
		else if (start)
			snap_r <= free_cnt_r;
	end

	always_comb begin
		src = SRC_CSR;
		if (bus.fifo_sel)
			src = SRC_RXD;
		else if ({bus.addr, 1'b0} < `ADDR_RX_STS)
			src = SRC_RXD;
		else if ({bus.addr[7:3], 3'h0} == `ADDR_RX_STS)
			src = SRC_RXS;
		else if ({bus.addr[7:3], 3'h0} == `ADDR_TX_STS)
			src = SRC_TXS;
	end

	// a[1] picks the half of fifo words in 16-bit mode, csr upper halves read zero; a[2] only aliases inside fifo windows
	always_comb begin
		rd_val = 32'h0;
		case ({bus.addr, 1'b0})
			`ADDR_BYTE_PROBE: rd_val = `BYTE_PROBE_VAL;
			`ADDR_FREE_CNT: rd_val = start ? free_cnt_r : snap_r;
			`ADDR_RX_FILL: rd_val = {16'h0, i_rx_fill};
			default: rd_val = 32'h0;
		endcase
		case (src)
			SRC_RXD: rd_val = (buf_cnt_r != 2'h0) ? buf_d[buf_rd_r] : 32'h0;
			SRC_RXS: rd_val = i_rxs_valid ? i_rxs_data : 32'h0;
			SRC_TXS: rd_val = i_txs_valid ? i_txs_data : 32'h0;
			default: ;
		endcase
		if (BUS16 != 0 && bus.addr[1])
			rd_val = {16'h0, rd_val[31:`DATA_HI_LSB]};
	end

	// fifo word retires on each new access, 16-bit retires on upper half
	assign pop = (start || step) && (BUS16 == 0 || bus.addr[1]);

	// one word moves in and one out per clock at most
	assign push = o_rxd_ready && i_rxd_valid;
	assign take = pop && src == SRC_RXD && buf_cnt_r != 2'h0;

	// storage needs no reset: the count says which entries hold data
	always_ff @(posedge i_clk) begin
		if (push)
			buf_d[buf_wr_r] <= i_rxd_data;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			buf_wr_r <= 1'b0;
		else if (push)
			buf_wr_r <= !buf_wr_r;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			buf_rd_r <= 1'b0;
		else if (take)
			buf_rd_r <= !buf_rd_r;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			buf_cnt_r <= 2'h0;
		else
			buf_cnt_r <= buf_cnt_r + {1'b0, push} - {1'b0, take};
	end

	// ready looks at the count and push but not at take, so a pop frees space one clock late
	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_rxd_ready <= 1'b0;
		else
			o_rxd_ready <= (buf_cnt_r == 2'h0) || (buf_cnt_r == 2'h1 && !push);
	end

	// status pops are one-clock pulses; the forced gap stops a double pop
	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_rxs_ready <= 1'b0;
		else
			o_rxs_ready <= pop && src == SRC_RXS && i_rxs_valid && !o_rxs_ready;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_txs_ready <= 1'b0;
		else
			o_txs_ready <= pop && src == SRC_TXS && i_txs_valid && !o_txs_ready;
	end

	// data moves only when a beat opens, so a pop cannot disturb the word shown
	always_ff @(posedge i_clk) begin
		if (i_rst)
			dout_r <= '0;
		else if (start || step)
			dout_r <= rd_val;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			oe_r <= 2'b00;
		else if (cyc_on)
			oe_r <= (BUS16 != 0) ? 2'b01 : 2'b11;
		else
			oe_r <= 2'b00;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_active <= 1'b0;
		else
			o_active <= cyc_on;
	end

	assign bus.data_out = dout_r;
	assign bus.data_oe = oe_r;
endmodule
`default_nettype wire

// *** logic/pio_rd_defines.svh ***
// pio_rd_defines.svh: address map, field positions and timing counts for the host read port
// assumes a 20 MHz system clock on both ends
`ifndef PIO_RD_DEFINES_SVH
`define PIO_RD_DEFINES_SVH
`define CLK_PERIOD_NS 50
`define T_CSH_NS 13
`define T_CSH_CYC (((`T_CSH_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define T_CYCLE_NS 45
`define T_CSL_NS 32
`define T_CSL_CYC (((`T_CSL_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define T_FIFO_INF_WAIT_NS 135
`define T_FIFO_INF_WAIT_CYC (((`T_FIFO_INF_WAIT_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define BURST_MAX_32 8
`define BURST_MAX_16 16
`define ADDR_W 8
`define ADDR_RX_DATA 8'h00
`define ADDR_RX_STS 8'h40
`define ADDR_TX_STS 8'h48
`define ADDR_RX_FILL 8'h7c
`define ADDR_BYTE_PROBE 8'h64
`define ADDR_FREE_CNT 8'h9c
`define BYTE_PROBE_VAL 32'h87654321
`define DATA_HI_LSB 16
`endif

// *** logic/pio_rd_pkg.sv ***
// pio_rd_pkg.sv: shared types for both ends of the host read port
// assumes pio_rd_defines.svh supplies the numeric constants
`default_nettype none
package pio_rd_pkg;
	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_WAIT = 4'b0010,
		H_STROBE = 4'b0100,
		H_GAP = 4'b1000
	} host_state_t;
	typedef enum logic [1:0] {
		SRC_CSR = 2'b00,
		SRC_RXD = 2'b01,
		SRC_RXS = 2'b10,
		SRC_TXS = 2'b11
	} rd_src_t;
endpackage
`default_nettype wire

// *** logic/pio_rd_if.sv ***
// pio_rd_if.sv: host port pins between the host controller and the device end
// assumes one shared clock; the data bus wire is resolved from the enables by the bench
`timescale 1ns/1ps
`default_nettype none
interface pio_rd_if;
	logic host_select_n;
	logic host_read_strobe_n;
	logic [7:1] addr;
	logic fifo_sel;
	logic end_sel;
	logic [31:0] data_out;
	logic [1:0] data_oe;
	logic [31:0] data_in;
	modport dev (input host_select_n, input host_read_strobe_n, input addr, input fifo_sel, input end_sel,
		output data_out, output data_oe, input data_in);
	modport host (output host_select_n, output host_read_strobe_n, output addr, output fifo_sel,
		output end_sel, input data_in);
endinterface
`default_nettype wire

// *** logic/pio_rd_host.sv ***
// pio_rd_host.sv: host end that runs single and burst reads on the device port
// assumes one shared clock; a request starts a burst of i_len beats at i_addr, one beat when i_len is zero
`timescale 1ns/1ps
`default_nettype none
`include "pio_rd_defines.svh"
module pio_rd_host import pio_rd_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	pio_rd_if.host bus,
	input wire logic i_req,
	input wire logic [7:1] i_addr,
	input wire logic i_fifo_sel,
	input wire logic [4:0] i_len,
	output logic o_busy,
	output logic o_rd_valid,
	output logic [31:0] o_rd_data
);
	host_state_t st_r;
	logic [4:0] left_r;
	logic [1:0] cnt_r;
	logic [7:0] fill_wait_r;
	logic last_rx_r;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_r <= H_IDLE;
			left_r <= '0;
			cnt_r <= '0;
			bus.host_select_n <= 1'b1;
			bus.host_read_strobe_n <= 1'b1;
			bus.addr <= '0;
			bus.fifo_sel <= 1'b0;
			bus.end_sel <= 1'b0;
			o_busy <= 1'b0;
			o_rd_valid <= 1'b0;
			o_rd_data <= '0;
		end else begin
			o_rd_valid <= 1'b0;
			case (st_r)
				H_IDLE: begin
					if (i_req) begin
						bus.addr <= i_addr;
						bus.fifo_sel <= i_fifo_sel;
						left_r <= (i_len == 5'h0) ? 5'h1 : i_len;
						o_busy <= 1'b1;
						st_r <= H_WAIT;
					end
				end
				H_WAIT: begin
					// fill info must not follow an rx read too closely
					if (!({bus.addr, 1'b0} == `ADDR_RX_FILL && fill_wait_r != 8'h0)) begin
						bus.host_select_n <= 1'b0;
						bus.host_read_strobe_n <= 1'b0;
						cnt_r <= 2'(`T_CSL_CYC);
						st_r <= H_STROBE;
					end
				end
				H_STROBE: begin
					if (cnt_r != 2'h0) begin
						cnt_r <= cnt_r - 2'h1;
					end else begin
						o_rd_valid <= 1'b1;
						o_rd_data <= bus.data_in;
						if (left_r > 5'h1) begin
							left_r <= left_r - 5'h1;
							bus.addr <= bus.addr + 7'h2;
							cnt_r <= 2'(`T_CSL_CYC);
						end else begin
							bus.host_read_strobe_n <= 1'b1;
							bus.host_select_n <= 1'b1;
							cnt_r <= 2'(`T_CSH_CYC);
							st_r <= H_GAP;
						end
					end
				end
				H_GAP: begin
					if (cnt_r > 2'h1)
						cnt_r <= cnt_r - 2'h1;
					else begin
						o_busy <= 1'b0;
						st_r <= H_IDLE;
					end
				end
				default: st_r <= H_IDLE;
			endcase
		end
	end

	// cycles left before the fill info register may be trusted
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			fill_wait_r <= '0;
			last_rx_r <= 1'b0;
		end else begin
			last_rx_r <= st_r == H_STROBE && (bus.fifo_sel || {bus.addr, 1'b0} < `ADDR_TX_STS);
			if (last_rx_r)
				fill_wait_r <= 8'(`T_FIFO_INF_WAIT_CYC);
			else if (fill_wait_r != 8'h0)
				fill_wait_r <= fill_wait_r - 8'h1;
		end
	end
endmodule
`default_nettype wire

// *** bench/pio_rd_monitor.sv ***
// pio_rd_monitor.sv: checker on the host read port pins
// assumes one clock, synchronous high reset, 32-bit device unless BUS16
`timescale 1ns/1ps
`default_nettype none
module pio_rd_monitor #(
	parameter int BUS16 = 0
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic host_select_n,
	input wire logic host_read_strobe_n,
	input wire logic [7:1] addr,
	input wire logic fifo_sel,
	input wire logic [31:0] data_out,
	input wire logic [1:0] data_oe
);
	logic act;
	logic act_r;
	logic [7:1] addr_r;
	logic [4:0] steps_r;
	assign act = !host_select_n && !host_read_strobe_n;
	always_ff @(posedge i_clk) act_r <= act;
	always_ff @(posedge i_clk) addr_r <= addr;
	// address steps inside one strobe window, first beat not counted
	always_ff @(posedge i_clk) begin
		if (i_rst || !act)
			steps_r <= 5'h00;
		else if (act_r && addr != addr_r)
			steps_r <= steps_r + 5'h01;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	chk_bus_release: assert property (!act |=> data_oe == 2'b00)
		else $error("data bus driven outside a read cycle");
	chk_bus_drive: assert property (act |=> data_oe == ((BUS16 != 0) ? 2'b01 : 2'b11))
		else $error("data bus not driven during a read cycle");
	chk_lane_pair: assert property (BUS16 == 0 |-> data_oe[0] == data_oe[1])
		else $error("data lanes enabled apart in wide mode");
	chk_beat_hold: assert property ($rose(act) |-> act [*2])
		else $error("read strobes released too early");
	chk_burst_len: assert property (!fifo_sel |-> steps_r <= ((BUS16 != 0) ? 5'h0f : 5'h07))
		else $error("burst longer than the allowed beat count");
	chk_addr_step: assert property (act && act_r && addr != addr_r |-> addr == addr_r + 7'h02)
		else $error("burst address step is not one dword");
	chk_sel_steady: assert property (act && act_r |-> $stable(fifo_sel))
		else $error("fifo select changed inside a cycle");
	chk_data_held: assert property (act && act_r && addr == addr_r |=> $stable(data_out))
		else $error("read data changed within one beat");
	cover property (steps_r == 5'h07);
	cover property (act && fifo_sel && steps_r == 5'h0a);
	cover property ($fell(act));
endmodule
`default_nettype wire

// *** bench/host_pio_read_port_tb.sv ***
// host_pio_read_port_tb.sv: host end and device end joined, streams modelled here
// assumes the logic files compile first
`timescale 1ns/1ps
`default_nettype none
`include "pio_rd_defines.svh"
`define tb_eq(g, e) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("unexpected at %0t: got %h want %h", $time, (g), (e)); \
	end \
end
module host_pio_read_port_tb;
	typedef struct {logic [7:1] a; logic f; logic [4:0] n; logic rx; logic [31:0] v;} row_t;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_req = 1'b0;
	logic [7:1] i_addr = 7'h00;
	logic i_fifo_sel = 1'b0;
	logic [4:0] i_len = 5'h01;
	logic src_valid = 1'b1;
	logic o_busy, o_rd_valid, o_rxd_ready;
	logic o_active, o_rxs_ready, o_txs_ready;
	logic [3:0] rxs_n = 4'h0;
	logic [3:0] txs_n = 4'h0;
	logic [31:0] o_rd_data;
	logic [15:0] rx_n = 16'h0000;
	logic [15:0] exp_n = 16'h0000;
	int fail_count = 0;
	int n_checks = 0;
	row_t rows [7];
	pio_rd_if bus_if ();
	assign bus_if.data_in = {bus_if.data_oe[1] ? bus_if.data_out[31:16] : 16'hzzzz,
		bus_if.data_oe[0] ? bus_if.data_out[15:0] : 16'hzzzz};
	always #25 i_clk = ~i_clk;
	always @(posedge i_clk) if (o_rxd_ready && src_valid) rx_n <= rx_n + 16'h0001;
	always @(posedge i_clk) if (o_rxs_ready) rxs_n <= rxs_n + 4'h1;
	always @(posedge i_clk) if (o_txs_ready) txs_n <= txs_n + 4'h1;
	pio_rd_dev #(.BUS16(0)) u_pio_rd_dev (.i_clk(i_clk), .i_rst(i_rst), .bus(bus_if.dev),
		.i_rxd_data({16'ha000, rx_n}), .i_rxd_valid(src_valid), .o_rxd_ready(o_rxd_ready),
		.i_rxs_data(32'h5a5a0001), .i_rxs_valid(src_valid), .o_rxs_ready(o_rxs_ready), .i_txs_data(32'h3c3c0002),
		.i_txs_valid(src_valid), .o_txs_ready(o_txs_ready), .i_rx_fill(16'h0123), .o_active(o_active));
	pio_rd_host u_pio_rd_host (.i_clk(i_clk), .i_rst(i_rst), .bus(bus_if.host), .i_req(i_req), .i_addr(i_addr),
		.i_fifo_sel(i_fifo_sel), .i_len(i_len), .o_busy(o_busy), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data));
	pio_rd_monitor #(.BUS16(0)) u_pio_rd_monitor (.i_clk(i_clk), .i_rst(i_rst),
		.host_select_n(bus_if.host_select_n), .host_read_strobe_n(bus_if.host_read_strobe_n),
		.addr(bus_if.addr), .fifo_sel(bus_if.fifo_sel), .data_out(bus_if.data_out), .data_oe(bus_if.data_oe));
	// rx words come in order; once the buffer is drained a read gives zero
	task automatic rd(input row_t r);
		int k;
		@(negedge i_clk);
		{i_addr, i_fifo_sel, i_len, i_req} = {r.a, r.f, r.n, 1'b1};
		@(negedge i_clk);
		i_req = 1'b0;
		for (int b = 0; b < r.n; b++) begin
			k = 0;
			while (o_rd_valid !== 1'b1 && k < 20) begin
				@(negedge i_clk);
				k++;
			end
			`tb_eq(o_rd_valid, 1'b1)
			`tb_eq(o_active, 1'b1)
			if (r.rx && rx_n != exp_n) begin
				`tb_eq(o_rd_data, {16'ha000, exp_n})
				exp_n = exp_n + 16'h0001;
			end else
				`tb_eq(o_rd_data, r.rx ? 32'h00000000 : r.v)
			@(negedge i_clk);
		end
		// spacing also covers the wait before a fill-info read
		repeat (4) @(negedge i_clk);
	endtask
	initial begin
		rows = '{'{7'h32, 1'b0, 5'h01, 1'b0, `BYTE_PROBE_VAL}, '{7'h00, 1'b0, 5'h08, 1'b1, 32'h0},
			'{7'h20, 1'b0, 5'h01, 1'b0, 32'h5a5a0001}, '{7'h24, 1'b0, 5'h01, 1'b0, 32'h3c3c0002},
			'{7'h3e, 1'b0, 5'h01, 1'b0, 32'h00000123}, '{7'h40, 1'b0, 5'h01, 1'b0, 32'h0},
			'{7'h3c, 1'b1, 5'h0c, 1'b1, 32'h0}};
		repeat (5) @(posedge i_clk);
		@(negedge i_clk);
		i_rst = 1'b0;
		`tb_eq(o_busy, 1'b0)
		`tb_eq(bus_if.data_oe, 2'b00)
		$display("reset test done");
		foreach (rows[i]) begin
			rd(rows[i]);
			$display("row %0d done", i);
		end
		`tb_eq(rxs_n, 4'h1)
		`tb_eq(txs_n, 4'h1)
		src_valid = 1'b0;
		rd('{7'h7c, 1'b1, 5'h04, 1'b1, 32'h0});
		src_valid = 1'b1;
		repeat (4) @(negedge i_clk);
		rd('{7'h00, 1'b1, 5'h02, 1'b1, 32'h0});
		$display("drain test done");
		// words in the buffer are lost in reset, so the model sets its expected count to rx_n
		i_rst = 1'b1;
		repeat (2) @(negedge i_clk);
		exp_n = rx_n;
		i_rst = 1'b0;
		`tb_eq(o_active, 1'b0)
		`tb_eq(bus_if.data_oe, 2'b00)
		// counter restarts at zero; the read opens on the third edge after release
		rd('{7'h4e, 1'b0, 5'h01, 1'b0, 32'h00000003});
		rd('{7'h02, 1'b0, 5'h01, 1'b1, 32'h0});
		$display("mid-run reset test done");
		conclude();
	end
	initial begin
		repeat (3000) @(posedge i_clk);
		fail_count++;
		conclude();
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
endmodule
`default_nettype wire
